// File: rtl/temp_sensor_id_resolution_shutdown.sv
// Serial-reachable register bank: ambient reading, identity, precision, shutdown
`timescale 1ns/1ps
module temp_sensor_id_resolution_shutdown #(
	parameter int unsigned CONV_US_HALF      = temp_sense_pkg::CONV_US_0,
	parameter int unsigned CONV_US_QUARTER   = temp_sense_pkg::CONV_US_1,
	parameter int unsigned CONV_US_EIGHTH    = temp_sense_pkg::CONV_US_2,
	parameter int unsigned CONV_US_SIXTEENTH = temp_sense_pkg::CONV_US_3,
	parameter logic [15:0] MAKER_CODE        = 16'h1A2B, // Arbitrary value
	parameter logic [7:0]  PART_CODE         = 8'h5C,    // Arbitrary value
	parameter logic [7:0]  REV_FIRST         = 8'h03,    // Arbitrary value
	parameter logic [7:0]  REV_STEPS         = 8'h00
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda,
	output logic             o_sda_oe,
	input  wire logic [2:0]  i_addr_pins,
	input  wire logic        i_lock_hi,
	input  wire logic        i_lock_lo,
	input  wire logic [12:0] i_adc_word,
	input  wire logic        i_crit_flag,
	input  wire logic        i_upper_flag,
	input  wire logic        i_lower_flag,
	input  wire logic        i_alarm_req,
	output logic             o_alarm,
	output logic             o_sampling_en,
	output logic             o_conv_done,
	output temp_sense_pkg::res_sel_t o_res_active
);
	import temp_sense_pkg::*;

	localparam logic [CONV_CNT_W-1:0] CNT_0 = CONV_CNT_W'(CONV_US_HALF * CLK_MHZ - 1);
	localparam logic [CONV_CNT_W-1:0] CNT_1 = CONV_CNT_W'(CONV_US_QUARTER * CLK_MHZ - 1);
	localparam logic [CONV_CNT_W-1:0] CNT_2 = CONV_CNT_W'(CONV_US_EIGHTH * CLK_MHZ - 1);
	localparam logic [CONV_CNT_W-1:0] CNT_3 = CONV_CNT_W'(CONV_US_SIXTEENTH * CLK_MHZ - 1);

	function automatic logic [CONV_CNT_W-1:0] period_of(input res_sel_t r);
		unique case (r)
			RES_HALF:      period_of = CNT_0;
			RES_QUARTER:   period_of = CNT_1;
			RES_EIGHTH:    period_of = CNT_2;
			RES_SIXTEENTH: period_of = CNT_3;
		endcase
	endfunction : period_of

	// Fraction bits below the selected LSB weight are forced clear
	function automatic logic [12:0] frac_mask(input res_sel_t r);
		unique case (r)
			RES_HALF:      frac_mask = 13'h1FF8;
			RES_QUARTER:   frac_mask = 13'h1FFC;
			RES_EIGHTH:    frac_mask = 13'h1FFE;
			RES_SIXTEENTH: frac_mask = 13'h1FFF;
		endcase
	endfunction : frac_mask

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic [1:0] adr_sync0_r;
	logic [1:0] adr_sync1_r;
	logic [1:0] adr_sync2_r;
	logic       scl_d_r;
	logic       sda_d_r;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_sync_r  <= 2'h3;
			sda_sync_r  <= 2'h3;
			adr_sync0_r <= 2'h0;
			adr_sync1_r <= 2'h0;
			adr_sync2_r <= 2'h0;
			scl_d_r     <= 1'b1;
			sda_d_r     <= 1'b1;
		end else begin
			scl_sync_r  <= {scl_sync_r[0], i_scl};
			sda_sync_r  <= {sda_sync_r[0], i_sda};
			adr_sync0_r <= {adr_sync0_r[0], i_addr_pins[0]};
			adr_sync1_r <= {adr_sync1_r[0], i_addr_pins[1]};
			adr_sync2_r <= {adr_sync2_r[0], i_addr_pins[2]};
			scl_d_r     <= scl_sync_r[1];
			sda_d_r     <= sda_sync_r[1];
		end
	end

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [6:0] own_addr;

	assign scl_s     = scl_sync_r[1];
	assign sda_s     = sda_sync_r[1];
	assign scl_rise  = scl_s & ~scl_d_r;
	assign scl_fall  = ~scl_s & scl_d_r;
	assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;
	assign own_addr  = {DEV_TYPE_CODE, adr_sync2_r[1], adr_sync1_r[1], adr_sync0_r[1]};

	// ------------------------------------------------------------
	// Register contents
	// ------------------------------------------------------------
	slave_state_t state_r;
	logic [7:0]   ptr_r;
	logic [7:0]   rx_r;
	logic [7:0]   tx_r;
	logic [7:0]   msb_hold_r;
	logic [15:0]  rd_word_r;
	logic [3:0]   bit_cnt_r;
	logic [1:0]   wr_idx_r;
	logic         rd_lsb_r;
	logic         rd_dir_r;
	logic         shutdown_r;
	res_sel_t     prec_r;
	res_sel_t     res_act_r;
	logic [15:0]  ambient_r;
	logic [CONV_CNT_W-1:0] conv_cnt_r;

	logic        locked;
	logic        byte_done;
	logic        ptr_wr;
	logic        prec_wr;
	logic        cfg_wr;
	logic [15:0] wr_word;
	logic [15:0] cap_word;
	logic [15:0] sel_word;
	logic        conv_load;

	assign locked    = i_lock_hi | i_lock_lo;
	assign byte_done = scl_fall && (bit_cnt_r == BITS_PER_BYTE);
	assign ptr_wr    = (state_r == ST_WRITE) && byte_done && (wr_idx_r == 2'h0);
	assign prec_wr   = (state_r == ST_WRITE) && byte_done && (wr_idx_r == 2'h1)
			&& (ptr_r == PTR_PRECISION);
	assign cfg_wr    = (state_r == ST_WRITE) && byte_done && (wr_idx_r == 2'h2)
			&& (ptr_r == PTR_CONFIG);
	assign wr_word   = {msb_hold_r, rx_r};
	assign conv_load = !shutdown_r && (conv_cnt_r == '0);

	always_comb begin
		cap_word = CAP_OTHER_BITS;
		cap_word[CAP_RES_LSB +: 2] = prec_r;                  // [RULE13] [RULE20]
	end

	always_comb begin
		sel_word = 16'h0000;                                   // [RULE12]
		unique case (ptr_r)
			PTR_CAPABILITY: sel_word = cap_word;
			PTR_CONFIG: begin
				sel_word[CFG_SHUTDOWN_BIT] = shutdown_r;
				sel_word[CFG_LOCK_HI_BIT]  = i_lock_hi;
				sel_word[CFG_LOCK_LO_BIT]  = i_lock_lo;
			end
			PTR_AMBIENT:   sel_word = ambient_r;
			PTR_MAKER_ID:  sel_word = MAKER_CODE;                      // [RULE6]
			PTR_PART_REV:  sel_word = {PART_CODE, REV_FIRST + REV_STEPS}; // [RULE8] [RULE9]
			PTR_PRECISION: sel_word = {8'h00, 6'h00, prec_r};           // [RULE12]
			default:       sel_word = 16'h0000;
		endcase
	end

	// ------------------------------------------------------------
	// Serial slave state machine
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r   <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			rx_r      <= 8'h00;
			tx_r      <= 8'h00;
			rd_dir_r  <= 1'b0;
			rd_lsb_r  <= 1'b0;
			wr_idx_r  <= 2'h0;
			rd_word_r <= 16'h0000;
			o_sda_oe  <= 1'b0;
		end else if (bus_start) begin
			state_r   <= ST_ADDR;
			bit_cnt_r <= 4'h0;
			o_sda_oe  <= 1'b0;
		end else if (bus_stop) begin
			state_r  <= ST_IDLE;
			o_sda_oe <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: o_sda_oe <= 1'b0;
				ST_ADDR, ST_WRITE: begin
					if (scl_rise) begin
						rx_r      <= {rx_r[6:0], sda_s};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (byte_done) begin
						if (state_r == ST_WRITE) begin
							state_r  <= ST_ACK_W;
							o_sda_oe <= 1'b1;
							if (wr_idx_r != 2'h3)
								wr_idx_r <= wr_idx_r + 2'h1;
						end else if (rx_r[7:1] == own_addr) begin
							state_r   <= ST_ACK_A;
							o_sda_oe  <= 1'b1;
							rd_dir_r  <= rx_r[0];
							// Snapshot so both bytes come from one conversion
							rd_word_r <= sel_word;
						end else begin
							state_r <= ST_IDLE;
						end
					end
				end
				ST_ACK_A: if (scl_fall) begin
					bit_cnt_r <= 4'h0;
					wr_idx_r  <= 2'h0;
					if (rd_dir_r) begin
						state_r  <= ST_READ;
						tx_r     <= rd_word_r[15:8];                 // [RULE1]
						rd_lsb_r <= 1'b1;
						o_sda_oe <= ~rd_word_r[15];
						if (ptr_r == PTR_PRECISION) begin
							tx_r     <= rd_word_r[7:0];
							o_sda_oe <= ~rd_word_r[7];
						end
					end else begin
						state_r  <= ST_WRITE;
						o_sda_oe <= 1'b0;
					end
				end
				ST_ACK_W: if (scl_fall) begin
					state_r   <= ST_WRITE;
					bit_cnt_r <= 4'h0;
					o_sda_oe  <= 1'b0;
				end
				ST_READ: begin
					if (scl_rise) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (byte_done) begin
						state_r  <= ST_ACK_R;
						o_sda_oe <= 1'b0;
					end else if (scl_fall) begin
						tx_r     <= {tx_r[6:0], 1'b0};
						o_sda_oe <= ~tx_r[6];
					end
				end
				ST_ACK_R: begin
					if (scl_rise && sda_s) begin
						state_r <= ST_IDLE;
					end else if (scl_fall) begin
						state_r   <= ST_READ;
						bit_cnt_r <= 4'h0;
						rd_lsb_r  <= ~rd_lsb_r;
						tx_r      <= rd_lsb_r ? rd_word_r[7:0] : rd_word_r[15:8]; // [RULE1]
						o_sda_oe  <= rd_lsb_r ? ~rd_word_r[7] : ~rd_word_r[15];
						if (ptr_r == PTR_PRECISION) begin
							tx_r     <= rd_word_r[7:0];
							o_sda_oe <= ~rd_word_r[7];
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Open-drain: the data level is always low, only the enable moves
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_sda <= 1'b0;
		else
			o_sda <= 1'b0;
	end

	// ------------------------------------------------------------
	// Register writes; none is gated by shutdown
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			ptr_r <= PTR_CAPABILITY;
		else if (ptr_wr)
			ptr_r <= rx_r;                                     // [RULE7]
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			msb_hold_r <= 8'h00;
		else if ((state_r == ST_WRITE) && byte_done && (wr_idx_r == 2'h1))
			msb_hold_r <= rx_r;
	end

	// Identification pointers have no write path at all
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			prec_r <= res_sel_t'(PREC_RESET);                  // [RULE10]
		else if (prec_wr)
			prec_r <= res_sel_t'(rx_r[1:0]);                   // [RULE10] [RULE17] [RULE21]
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			shutdown_r <= 1'b0;
		else if (cfg_wr) begin
			if (!wr_word[CFG_SHUTDOWN_BIT])
				shutdown_r <= 1'b0;                            // [RULE15] [RULE16]
			else if (!locked)
				shutdown_r <= 1'b1;                            // [RULE14] [RULE16]
		end
	end

	// ------------------------------------------------------------
	// Conversion engine
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			conv_cnt_r <= CNT_1;
			res_act_r  <= res_sel_t'(PREC_RESET);
		end else if (conv_load) begin
			conv_cnt_r <= period_of(prec_r);                   // [RULE11] [RULE22]
			res_act_r  <= prec_r;                              // [RULE22]
		end else if (!shutdown_r) begin
			conv_cnt_r <= conv_cnt_r - 1'b1;                   // [RULE14]
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			ambient_r <= 16'h0000;
		else if (conv_load)
			ambient_r <= {i_crit_flag, i_upper_flag, i_lower_flag,   // [RULE4]
					i_adc_word & frac_mask(res_act_r)};              // [RULE5] [RULE19]
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_conv_done   <= 1'b0;
			o_sampling_en <= 1'b0;
			o_res_active  <= res_sel_t'(PREC_RESET);
		end else begin
			o_conv_done   <= conv_load;
			o_sampling_en <= !shutdown_r;                      // [RULE14]
			o_res_active  <= res_act_r;
		end
	end

	// Alarm freezes while shut down, so an active alarm stays active
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_alarm <= 1'b0;
		else if (!shutdown_r)
			o_alarm <= i_alarm_req;                            // [RULE18]
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_lock_blocks_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE16]
		cfg_wr && wr_word[CFG_SHUTDOWN_BIT] && locked && !shutdown_r |=> !shutdown_r)
		else $error("shutdown set while locked");
	a_clear_while_lock: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE16]
		cfg_wr && !wr_word[CFG_SHUTDOWN_BIT] |=> !shutdown_r)
		else $error("shutdown clear refused");
	a_sd_stops_conv: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE14]
		shutdown_r |=> $stable(ambient_r) && !o_conv_done && !o_sampling_en)
		else $error("conversion ran in shutdown");
	a_alarm_held_sd: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE18]
		shutdown_r && o_alarm |=> o_alarm)
		else $error("alarm dropped in shutdown");
	a_period_reload: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE11]
		conv_load |=> conv_cnt_r == period_of(res_act_r) && res_act_r == $past(prec_r))
		else $error("wrong conversion period");
	a_frac_cleared: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE10]
		conv_load && res_act_r == RES_HALF |=> ambient_r[2:0] == 3'h0)
		else $error("fraction bits not cleared");
	a_flags_loaded: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE4]
		conv_load |=> ambient_r[AMB_CRIT_BIT] == $past(i_crit_flag)
			&& ambient_r[AMB_UPPER_BIT] == $past(i_upper_flag)
			&& ambient_r[AMB_LOWER_BIT] == $past(i_lower_flag)
			&& ambient_r[AMB_SIGN_BIT] == $past(i_adc_word[12]))
		else $error("flags not loaded");
	a_ptr_retained: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE7]
		!ptr_wr |=> $stable(ptr_r))
		else $error("pointer lost");
	a_stop_release: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE17]
		bus_stop |=> !o_sda_oe && state_r == ST_IDLE)
		else $error("data line held after stop");
	a_cap_mirror: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE13]
		prec_wr |=> cap_word[CAP_RES_LSB +: 2] == $past(rx_r[1:0]))
		else $error("capability not mirrored");
endmodule : temp_sensor_id_resolution_shutdown

// File: rtl/temp_sense_pkg.sv
// Constants, register map and field layout of the sensor register bank
// Notes on behaviour
// RULE1: Reading goes high byte first, then low byte
// RULE2: Host decodes negative readings as 256 minus value
// RULE3: Host reads ambient via pointer write, repeated start
// RULE4: High byte carries critical, upper, lower flags
// RULE5: Sign sits at bit 12, set below zero
// RULE6: Read-only sixteen-bit maker code register
// RULE7: Pointer is kept between transactions
// RULE8: Part code high byte, revision low byte
// RULE9: Revision counts up from first release
// RULE10: Two-bit precision field selects LSB weight
// RULE11: Conversion period follows selected precision
// RULE12: Unimplemented bits read as zero
// RULE13: Capability register mirrors selected precision
// RULE14: Shutdown bit stops sampling, serial stays alive
// RULE15: Shutdown lasts until bit cleared or reset
// RULE16: Lock bits block setting shutdown, not clearing
// RULE17: Registers stay accessible during shutdown
// RULE18: Alarm asserted at shutdown stays active
// RULE19: Ambient register loads once per conversion
// RULE20: Precision shown in capability bits four, three
// RULE21: Writes to identification registers are ignored
// RULE22: Precision change applies from next conversion
package temp_sense_pkg;
	// ------------------------------------------------------------
	// Register pointers
	// ------------------------------------------------------------
	localparam logic [7:0] PTR_CAPABILITY   = 8'h00;
	localparam logic [7:0] PTR_CONFIG       = 8'h01;
	localparam logic [7:0] PTR_AMBIENT      = 8'h05;
	localparam logic [7:0] PTR_MAKER_ID     = 8'h06;
	localparam logic [7:0] PTR_PART_REV     = 8'h07;
	localparam logic [7:0] PTR_PRECISION    = 8'h08;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int          CFG_SHUTDOWN_BIT = 8;
	localparam int          CFG_LOCK_HI_BIT  = 7;
	localparam int          CFG_LOCK_LO_BIT  = 6;
	localparam int          CAP_RES_LSB      = 3;
	localparam int          AMB_CRIT_BIT     = 15;
	localparam int          AMB_UPPER_BIT    = 14;
	localparam int          AMB_LOWER_BIT    = 13;
	localparam int          AMB_SIGN_BIT     = 12;
	localparam logic [1:0]  PREC_RESET       = 2'h1;
	localparam logic [15:0] CAP_OTHER_BITS   = 16'h0000;

	typedef enum logic [1:0] {
		RES_HALF      = 2'h0,
		RES_QUARTER   = 2'h1,
		RES_EIGHTH    = 2'h2,
		RES_SIXTEENTH = 2'h3
	} res_sel_t;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ    = 40;
	localparam int          CONV_CNT_W = 24;
	localparam int unsigned CONV_US_0  = 30000;
	localparam int unsigned CONV_US_1  = 65000;
	localparam int unsigned CONV_US_2  = 130000;
	localparam int unsigned CONV_US_3  = 260000;

	// ------------------------------------------------------------
	// Serial slave
	// ------------------------------------------------------------
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] DEV_TYPE_CODE = 4'h3;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'b0000001,
		ST_ADDR  = 7'b0000010,
		ST_ACK_A = 7'b0000100,
		ST_WRITE = 7'b0001000,
		ST_ACK_W = 7'b0010000,
		ST_READ  = 7'b0100000,
		ST_ACK_R = 7'b1000000
	} slave_state_t;
endpackage : temp_sense_pkg

// File: tb/host_model.sv
// Behavioural two-wire host master that drives the sensor's serial pins
`timescale 1ns/1ps
module host_model (
	output logic      o_scl,
	output logic      o_sda_low,
	input  wire logic i_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	// ------------------------------------------------------------
	// Bus cycles, 200 ns per bit
	// ------------------------------------------------------------
	// Data moves 25 ns after the fall. The long low phase lets the slave
	// release its ACK before the clock rises, seen through its synchronisers.
	task automatic bit_x(input logic b, output logic s);
		#25 o_sda_low = ~b;
		#100 o_scl = 1'b1;
		#40 s = i_sda;
		#35 o_scl = 1'b0;
	endtask : bit_x

	// Also serves as the repeated start
	task automatic start();
		#25 o_sda_low = 1'b0;
		#125 o_scl = 1'b1;
		#100 o_sda_low = 1'b1;
		#100 o_scl = 1'b0;
	endtask : start

	task automatic stop();
		#25 o_sda_low = 1'b1;
		#125 o_scl = 1'b1;
		#100 o_sda_low = 1'b0;
		#100;
	endtask : stop

	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(b[i], s);
		bit_x(1'b1, s);
		ack = ~s;
	endtask : wr_byte

	// High byte is read with ACK, the last byte with NAK
	task automatic rd_byte(output logic [7:0] b, input logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, s);
			b[i] = s;
		end
		bit_x(~ack, s);
	endtask : rd_byte

	// Host decode of the reading, in sixteenths of a degree (magnitude)
	function automatic int degx16(input logic [7:0] hb, input logic [7:0] lb);
		logic [7:0] h;
		h = hb & 8'h1F;
		if (h[4]) return 4096 - (int'(h & 8'h0F) * 256 + int'(lb));
		return int'(h) * 256 + int'(lb);
	endfunction : degx16
endmodule : host_model

// File: tb/testbench.sv
// Self-checking bench for the sensor register bank over the serial port
`timescale 1ns/1ps
module testbench;
	import temp_sense_pkg::*;
	localparam logic [15:0] MAKER = 16'h3C5A; // Arbitrary value
	localparam logic [7:0]  PART  = 8'h47;    // Arbitrary value
	localparam logic [7:0]  REV0  = 8'h01;    // Arbitrary value
	localparam logic [7:0]  REVN  = 8'h02;
	localparam int          US[4] = '{2, 3, 4, 5};

	logic        core_clk  = 1'b0;
	logic        rst_n     = 1'b0;
	logic        scl;
	logic        sda_low;
	wire         sda_wire;
	logic [2:0]  addr_pins = 3'h0;
	logic        lock_hi   = 1'b0;
	logic        lock_lo   = 1'b0;
	logic [12:0] adc       = 13'h0000;
	logic        crit      = 1'b0;
	logic        upper     = 1'b0;
	logic        lower     = 1'b0;
	logic        alarm_req = 1'b0;
	logic        sda_out;
	logic        sda_oe;
	logic        alarm;
	logic        sampling_en;
	logic        conv_done;
	res_sel_t    res_active;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cyc       = 0;
	int          n;
	logic [31:0] rng       = 32'h661F4E27;
	logic [6:0]  dev_addr;
	logic [1:0]  prec_m;
	logic [15:0] v;
	logic [12:0] am;
	logic        a;

	// Open-drain data line with pull-up
	assign sda_wire = ~sda_low & (sda_oe ? sda_out : 1'b1);

	always #12.5 core_clk = ~core_clk;

	temp_sensor_id_resolution_shutdown #(
		.CONV_US_HALF     (US[0]),
		.CONV_US_QUARTER  (US[1]),
		.CONV_US_EIGHTH   (US[2]),
		.CONV_US_SIXTEENTH(US[3]),
		.MAKER_CODE       (MAKER),
		.PART_CODE        (PART),
		.REV_FIRST        (REV0),
		.REV_STEPS        (REVN)
	) u_temp_sensor_id_resolution_shutdown (
		.i_core_clk   (core_clk),
		.i_rst_n      (rst_n),
		.i_scl        (scl),
		.i_sda        (sda_wire),
		.o_sda        (sda_out),
		.o_sda_oe     (sda_oe),
		.i_addr_pins  (addr_pins),
		.i_lock_hi    (lock_hi),
		.i_lock_lo    (lock_lo),
		.i_adc_word   (adc),
		.i_crit_flag  (crit),
		.i_upper_flag (upper),
		.i_lower_flag (lower),
		.i_alarm_req  (alarm_req),
		.o_alarm      (alarm),
		.o_sampling_en(sampling_en),
		.o_conv_done  (conv_done),
		.o_res_active (res_active)
	);

	host_model u_host_model (
		.o_scl    (scl),
		.o_sda_low(sda_low),
		.i_sda    (sda_wire)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#2;
	endtask : tick

	task automatic chk(input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	task automatic wait_done(input int lim, output int cnt);
		cnt = 0;
		do begin
			tick(1);
			cnt++;
		end while (conv_done !== 1'b1 && cnt < lim);
	endtask : wait_done

	task automatic wr_reg(input logic [7:0] p, input logic [15:0] d, input int nb);
		logic ak;
		u_host_model.start();
		u_host_model.wr_byte({dev_addr, 1'b0}, ak);
		chk(16'h0001, {15'h0, ak});
		u_host_model.wr_byte(p, ak);
		for (int i = nb - 1; i >= 0; i--) u_host_model.wr_byte(d[8*i +: 8], ak);
		u_host_model.stop();
		if (p == PTR_PRECISION) prec_m = d[1:0];
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] p, input bit setp, input int nb,
		output logic [15:0] r);
		logic       ak;
		logic [7:0] b;
		r = 16'h0000;
		if (setp) begin
			u_host_model.start();
			u_host_model.wr_byte({dev_addr, 1'b0}, ak);
			u_host_model.wr_byte(p, ak);
		end
		u_host_model.start();
		u_host_model.wr_byte({dev_addr, 1'b1}, ak);
		chk(16'h0001, {15'h0, ak});
		for (int i = nb - 1; i >= 0; i--) begin
			u_host_model.rd_byte(b, i != 0);
			r[8*i +: 8] = b;
		end
		u_host_model.stop();
	endtask : rd_reg

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, 16'h0000, 16'(cyc));
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rng = xs(rng);
		addr_pins = rng[2:0];
		dev_addr = {DEV_TYPE_CODE, rng[2:0]};
		prec_m = PREC_RESET;
		repeat (12) @(posedge core_clk);
		#2 rst_n = 1'b1;
		tick(6);
		rd_reg(PTR_PRECISION, 1, 1, v);
		chk({14'h0, prec_m}, v);
		rd_reg(PTR_CAPABILITY, 1, 2, v);
		chk({11'h0, prec_m, 3'h0}, v);
		wr_reg(PTR_MAKER_ID, 16'hFFFF, 2);
		rd_reg(PTR_MAKER_ID, 0, 2, v);
		chk(MAKER, v);
		wr_reg(PTR_PART_REV, 16'h0000, 2);
		rd_reg(PTR_PART_REV, 0, 2, v);
		chk({PART, REV0 + REVN}, v);
		u_host_model.start();
		u_host_model.wr_byte({dev_addr ^ 7'h01, 1'b0}, a);
		u_host_model.stop();
		chk(16'h0000, {15'h0, a});
		$display("test identity done");
		for (int r = 3; r >= 0; r--) begin
			rng = xs(rng);
			tick(1);
			{crit, upper, lower, adc} = rng[15:0];
			wr_reg(PTR_PRECISION, 16'(r), 1);
			wait_done(2000, n);
			wait_done(2000, n);
			chk(16'(US[r] * 40), 16'(n));
			chk({14'h0, prec_m}, {14'h0, res_active});
			rd_reg(PTR_PRECISION, 1, 1, v);
			chk(16'(r), v);
			rd_reg(PTR_CAPABILITY, 1, 2, v);
			chk(16'(r) << 3, v);
			rd_reg(PTR_AMBIENT, 1, 2, v);
			am = adc & (13'h1FFF << (3 - r));
			chk({crit, upper, lower, am}, v);
			chk(16'(u_host_model.degx16(v[15:8], v[7:0])),
				16'(am[12] ? 8192 - int'(am) : int'(am)));
		end
		$display("test precision done");
		alarm_req = 1'b1;
		tick(3);
		chk(16'h0001, {15'h0, alarm});
		wr_reg(PTR_CONFIG, 16'h0100, 2);
		tick(1);
		alarm_req = 1'b0;
		tick(4);
		chk(16'h0000, {15'h0, sampling_en});
		rd_reg(PTR_CONFIG, 1, 2, v);
		chk(16'h0100, v);
		wait_done(400, n);
		chk(16'h0190, 16'(n));
		chk(16'h0001, {15'h0, alarm});
		wr_reg(PTR_PRECISION, 16'h0002, 1);
		rd_reg(PTR_PRECISION, 1, 1, v);
		chk(16'h0002, v);
		wr_reg(PTR_CONFIG, 16'h0000, 2);
		tick(4);
		chk(16'h0001, {15'h0, sampling_en});
		wait_done(1000, n);
		chk(16'h0001, {15'h0, conv_done});
		$display("test shutdown done");
		for (int k = 1; k < 4; k++) begin
			tick(1);
			{lock_hi, lock_lo} = 2'(k);
			wr_reg(PTR_CONFIG, 16'h0100, 2);
			tick(4);
			chk(16'h0001, {15'h0, sampling_en});
		end
		tick(1);
		{lock_hi, lock_lo} = 2'h0;
		wr_reg(PTR_CONFIG, 16'h0100, 2);
		tick(1);
		{lock_hi, lock_lo} = 2'h3;
		wr_reg(PTR_CONFIG, 16'h0000, 2);
		tick(4);
		chk(16'h0001, {15'h0, sampling_en});
		rd_reg(PTR_CONFIG, 1, 2, v);
		chk(16'h00C0, v);
		$display("test lock done");
		stop_test();
	end
endmodule : testbench
